// ==== hw/sbc_defines.svh ====
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH
// Contract
// - Turbo operation is off after power-up.
// - Start rise begins conversion, SDO goes high-impedance.
// - Completion with SDI low drives SDO low, enters low-power acquisition.
// - Result shifts out MSB first on falling edges.
// - Result on 20 falls, status on 21-26.
// - SDO released after extra fall or start rise.
// - Chain mode drives SDO low, also at start.
// - Chain completion shows MSB, then shifts on falls.
// - Chain captures SDI on every rising clock edge.
// - Chain writes shift in with start held low.
// - No register readback in chain mode.

`define SBC_RESULT_BITS 20
`define SBC_STATUS_BITS 6
`define SBC_WORD_BITS 26
`define SBC_POS_BITS 5
`define SBC_LEN_PLAIN 5'h14
`define SBC_LEN_STATUS 5'h1A
`define SBC_POS_MAX 5'h1F
`define SBC_CLK_MHZ 250
`define SBC_CONV_TIME_NS 300
`define SBC_TIMER_BITS 16
`define SBC_CMD_BITS 8
`define SBC_CFG_SR_BITS 16
`define SBC_PASS_TAP 7
`define SBC_WRITE_CMD 8'h14
`define SBC_CFG_TURBO_BIT 1
`define SBC_CFG_STATUS_BIT 0
`define SBC_CFG_RESET 1'h0

`endif

// ==== hw/sbc_pkg.sv ====
package sbc_pkg;
    typedef enum logic [1:0] {SBC_IDLE, SBC_CONVERT, SBC_READ} sbc_state_type;
endpackage

// ==== hw/sbc_sync.sv ====
`timescale 1ns/100ps
module sbc_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock
    input wire logic clk,
    // Levels from another domain
    input wire logic [WIDTH-1:0] async_in,
    // Levels after two flip-flops
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge clk) begin
        meta_r <= async_in;
        sync_r <= meta_r;
    end

    assign sync_out = sync_r;
endmodule

// ==== hw/sbc_readout.sv ====
`timescale 1ns/100ps
`include "sbc_defines.svh"
module sbc_readout #(
    parameter int CONV_TIME_NS = `SBC_CONV_TIME_NS
) (
    // System clock and reset
    input wire logic clk,
    input wire logic reset,
    // Serial link clock from the host
    input wire logic sck,
    // Host pins
    input wire logic convert_start,
    input wire logic sdi,
    input wire logic chain_mode,
    output logic sdo_o,
    output logic sdo_oe,
    // Converter core side
    input wire logic [`SBC_RESULT_BITS-1:0] result_data,
    input wire logic [`SBC_STATUS_BITS-1:0] status_data,
    output logic sample_start,
    output logic acquire,
    // Configuration state
    output logic turbo_en,
    output logic status_en,
    output sbc_pkg::sbc_state_type state
);
    import sbc_pkg::*;

    localparam int CONV_RAW = (CONV_TIME_NS * `SBC_CLK_MHZ + 999) / 1000;
    localparam int CONV_CYCLES = (CONV_RAW < 1) ? 1 : CONV_RAW;
    localparam logic [`SBC_TIMER_BITS-1:0] CONV_LAST = `SBC_TIMER_BITS'(CONV_CYCLES - 1);

    function automatic logic [`SBC_POS_BITS-1:0] word_len(input logic with_status);
        word_len = with_status ? `SBC_LEN_STATUS : `SBC_LEN_PLAIN;
    endfunction

    logic [2:0] pins_s;
    logic cnv_s;
    logic sdi_s;
    logic chain_s;
    logic rst_sck;

    sbc_sync #(.WIDTH(3)) u_pin_sync (
        .clk(clk),
        .async_in({convert_start, sdi, chain_mode}),
        .sync_out(pins_s)
    );

    sbc_sync #(.WIDTH(1)) u_rst_sync (
        .clk(sck),
        .async_in(reset),
        .sync_out(rst_sck)
    );

    assign cnv_s = pins_s[2];
    assign sdi_s = pins_s[1];
    assign chain_s = pins_s[0];

    sbc_state_type state_r, state_nxt;
    logic [`SBC_TIMER_BITS-1:0] timer_r, timer_nxt;
    logic cnv_prev_r, cnv_prev_nxt;
    logic mode_chain_r, mode_chain_nxt;
    logic ind_r, ind_nxt;
    logic [`SBC_WORD_BITS-1:0] word_r, word_nxt;
    logic [`SBC_POS_BITS-1:0] len_r, len_nxt;
    logic frame_tog_r, frame_tog_nxt;
    logic turbo_en_r, turbo_en_nxt;
    logic status_en_r, status_en_nxt;
    logic start_r, start_nxt;
    logic cnv_rise;

    logic sdi_r, sdi_nxt;
    logic [`SBC_CFG_SR_BITS-1:0] cfg_sr_r, cfg_sr_nxt;
    logic [`SBC_WORD_BITS-1:0] sr_r, sr_nxt;
    logic [`SBC_POS_BITS-1:0] cnt_r, cnt_nxt;
    logic seen_r, seen_nxt;
    logic first_w;
    logic [`SBC_POS_BITS-1:0] pos_w;
    logic tap_w;
    logic chain_now;

    assign cnv_rise = cnv_s && !cnv_prev_r;

    // Words, toggles and the configuration shifter are read across domains without
    // synchronisers: each one is still while the other side samples it, because the
    // serial clock stands idle during conversion and at the start edge.
    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        cnv_prev_nxt = cnv_s;
        mode_chain_nxt = mode_chain_r;
        ind_nxt = ind_r;
        word_nxt = word_r;
        len_nxt = len_r;
        frame_tog_nxt = frame_tog_r;
        turbo_en_nxt = turbo_en_r;
        status_en_nxt = status_en_r;
        start_nxt = 1'h0;
        unique case (state_r)
            SBC_IDLE, SBC_READ: begin
                if (cnv_rise) begin
                    state_nxt = SBC_CONVERT;
                    timer_nxt = CONV_LAST;
                    start_nxt = 1'h1;
                    mode_chain_nxt = chain_s;
                    if (state_r == SBC_IDLE && chain_s &&
                        cfg_sr_r[`SBC_CFG_SR_BITS-1 -: `SBC_CMD_BITS] == `SBC_WRITE_CMD) begin
                        turbo_en_nxt = cfg_sr_r[`SBC_CFG_TURBO_BIT];
                        status_en_nxt = cfg_sr_r[`SBC_CFG_STATUS_BIT];
                    end
                end else if (state_r == SBC_READ && !cnv_s) begin
                    state_nxt = SBC_IDLE;
                end
            end
            SBC_CONVERT: begin
                if (timer_r == '0) begin
                    state_nxt = SBC_READ;
                    len_nxt = word_len(status_en_r);
                    word_nxt = status_en_r ? {result_data, status_data} :
                        {{`SBC_STATUS_BITS{1'h0}}, result_data};
                    frame_tog_nxt = !seen_r;
                    ind_nxt = !sdi_s;
                end else begin
                    timer_nxt = timer_r - 1'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= SBC_IDLE;
            timer_r <= '0;
            cnv_prev_r <= 1'h0;
            mode_chain_r <= 1'h0;
            ind_r <= 1'h0;
            word_r <= '0;
            len_r <= `SBC_LEN_PLAIN;
            frame_tog_r <= 1'h0;
            turbo_en_r <= `SBC_CFG_RESET;
            status_en_r <= `SBC_CFG_RESET;
            start_r <= 1'h0;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            cnv_prev_r <= cnv_prev_nxt;
            mode_chain_r <= mode_chain_nxt;
            ind_r <= ind_nxt;
            word_r <= word_nxt;
            len_r <= len_nxt;
            frame_tog_r <= frame_tog_nxt;
            turbo_en_r <= turbo_en_nxt;
            status_en_r <= status_en_nxt;
            start_r <= start_nxt;
        end
    end

    // Rising edge: the chain input and the write shifter. The shifter delays by one
    // command byte, so a write ripples onward with a latency of eight clocks per device.
    always_comb begin
        sdi_nxt = sdi;
        cfg_sr_nxt = convert_start ? cfg_sr_r : {cfg_sr_r[`SBC_CFG_SR_BITS-2:0], sdi};
    end

    always_ff @(posedge sck) begin
        if (rst_sck) begin
            sdi_r <= 1'h0;
            cfg_sr_r <= '0;
        end else begin
            sdi_r <= sdi_nxt;
            cfg_sr_r <= cfg_sr_nxt;
        end
    end

    // Falling edge: the first fall of a frame loads the result, later ones shift.
    assign first_w = frame_tog_r != seen_r;

    always_comb begin
        sr_nxt = {sr_r[`SBC_WORD_BITS-2:0], sdi_r};
        cnt_nxt = (cnt_r == `SBC_POS_MAX) ? cnt_r : cnt_r + 1'h1;
        seen_nxt = seen_r;
        if (first_w) begin
            sr_nxt = mode_chain_r ? {word_r[`SBC_WORD_BITS-2:0], sdi_r} : word_r;
            cnt_nxt = 5'h01;
            seen_nxt = frame_tog_r;
        end
    end

    always_ff @(negedge sck) begin
        if (rst_sck) begin
            sr_r <= '0;
            cnt_r <= '0;
            seen_r <= 1'h0;
        end else begin
            sr_r <= sr_nxt;
            cnt_r <= cnt_nxt;
            seen_r <= seen_nxt;
        end
    end

    assign pos_w = first_w ? 5'h00 : cnt_r;
    assign tap_w = sr_r[len_r - 5'h01];
    assign chain_now = (state_r == SBC_IDLE) ? chain_s : mode_chain_r;

    // The pin mux is combinational so each bit follows its falling edge at once; a
    // registered copy on the system clock would lag the link by several cycles.
    always_comb begin
        sdo_oe = 1'h0;
        sdo_o = 1'h0;
        if (chain_now) begin
            sdo_oe = 1'h1;
            unique case (state_r)
                SBC_IDLE: sdo_o = cfg_sr_r[`SBC_PASS_TAP];
                SBC_CONVERT: sdo_o = 1'h0;
                SBC_READ: sdo_o = first_w ? word_r[len_r - 5'h01] : tap_w;
            endcase
        end else if (state_r == SBC_READ && ind_r && pos_w <= len_r) begin
            sdo_oe = 1'h1;
            sdo_o = first_w ? 1'h0 : tap_w;
        end
    end

    assign sample_start = start_r;
    assign acquire = state_r != SBC_CONVERT;
    assign turbo_en = turbo_en_r;
    assign status_en = status_en_r;
    assign state = state_r;

    a_turbo_off_reset: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> !turbo_en && !status_en)
        else $error("Turbo or status enabled after reset.");

    a_start_to_hiz: assert property (@(posedge clk) disable iff (reset)
        (state_r != SBC_CONVERT && cnv_rise && !chain_s) |=>
            state_r == SBC_CONVERT && !sdo_oe && sample_start)
        else $error("Start edge did not begin a conversion with SDO released.");

    a_done_drives_low: assert property (@(posedge clk) disable iff (reset)
        (state_r == SBC_CONVERT && timer_r == '0 && !mode_chain_r && !sdi_s) |=>
            state_r == SBC_READ && acquire && sdo_oe && !sdo_o)
        else $error("Completion did not drive SDO low.");

    a_conv_duration: assert property (@(posedge clk) disable iff (reset)
        $rose(state_r == SBC_CONVERT) |-> ##(CONV_CYCLES) $rose(state_r == SBC_READ))
        else $error("Conversion length is wrong.");

    a_word_length: assert property (@(posedge clk) disable iff (reset)
        $rose(state_r == SBC_READ) |-> len_r == (status_en_r ? 5'h1A : 5'h14))
        else $error("Frame length does not match the status setting.");

    a_chain_low: assert property (@(posedge clk) disable iff (reset)
        (mode_chain_r && state_r == SBC_CONVERT) |-> sdo_oe && !sdo_o)
        else $error("Chain mode SDO not low during conversion.");

    a_chain_msb: assert property (@(posedge clk) disable iff (reset)
        (mode_chain_r && $rose(state_r == SBC_READ)) |->
            sdo_oe && sdo_o == word_r[len_r - 5'h01])
        else $error("Chain completion did not show the MSB.");

    a_release_extra: assert property (@(posedge clk) disable iff (reset)
        (state_r == SBC_READ && !mode_chain_r && !first_w && cnt_r > len_r) |-> !sdo_oe)
        else $error("SDO still driven after the extra falling edge.");

    a_shift_order: assert property (@(negedge sck) disable iff (rst_sck)
        !first_w |=> sr_r[`SBC_WORD_BITS-1:1] == $past(sr_r[`SBC_WORD_BITS-2:0]))
        else $error("Output shifter did not advance by one bit.");

    a_chain_input: assert property (@(negedge sck) disable iff (rst_sck)
        !first_w |=> sr_r[0] == $past(sdi_r))
        else $error("Captured SDI did not enter the shifter.");
endmodule

// ==== tb/sbc_host_model.sv ====
`timescale 1ns/100ps
`include "sbc_defines.svh"
module sbc_host_model #(
    parameter int N_CHAIN = 2
) (
    // Host pins toward the converter
    output logic sck,
    output logic convert_start,
    output logic sdi,
    // Converter serial output
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    logic [1:0] got[$];
    logic feed[$];

    initial begin
        sck = 1'h0;
        convert_start = 1'h0;
        sdi = 1'h0;
    end

    // The readout length comes from the chain length, never from the device.
    function automatic int read_clocks(input logic status_on);
        return (status_on ? 26 : 20) * N_CHAIN;
    endfunction

    // SDI only changes while the clock is low, so every rising edge sees a settled bit.
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            sdi = (feed.size() > 0) ? feed.pop_front() : 1'h0;
            #1 got.push_back({sdo_oe, sdo_o});
            #2 sck = 1'h1;
            #3 sck = 1'h0;
        end
    endtask

    // The clock stays low from here until the readout starts.
    task automatic start_conv(input logic busy);
        sdi = busy;
        #7 convert_start = 1'h1;
        if (busy) begin
            #8 sdi = 1'h0;
        end
    endtask

    task automatic end_conv();
        convert_start = 1'h0;
    endtask

    // Command and data for the device n_dev places from the host.
    task automatic write_cfg(input logic [7:0] data, input int n_dev);
        logic [15:0] word;
        word = {`SBC_WRITE_CMD, data};
        for (int i = 0; i < 8 * (n_dev + 1); i++) begin
            feed.push_back((i < 16) ? word[15 - i] : 1'h0);
        end
        pulses(8 * (n_dev + 1));
    endtask
endmodule

// ==== tb/sar_adc_busy_and_chain_readout_tb_top.sv ====
`timescale 1ns/100ps
`include "sbc_defines.svh"
module sar_adc_busy_and_chain_readout_tb_top;
    import sbc_pkg::*;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic chain_mode = 1'h0;
    logic [19:0] result_data;
    logic [5:0] status_data;
    logic sck, convert_start, sdi, sdo_o, sdo_oe, sample_start, acquire, turbo_en, status_en;
    sbc_state_type state;
    int n_mismatch = 0;
    int checked = 0;
    int n_starts = 0;
    int seed = 32'hD039;
    logic exp_q[$];
    logic [25:0] up_word;
    logic [15:0] cfg_word;

    always #2 clk = ~clk;

    // The start pulse lasts one clock, so it is counted at every edge rather than polled.
    always @(posedge clk) begin
        if (sample_start === 1'h1) begin
            n_starts++;
        end
    end

    sbc_readout #(.CONV_TIME_NS(40)) sbc_readout_inst (.clk(clk), .reset(reset), .sck(sck),
        .convert_start(convert_start), .sdi(sdi), .chain_mode(chain_mode), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .result_data(result_data), .status_data(status_data),
        .sample_start(sample_start), .acquire(acquire), .turbo_en(turbo_en),
        .status_en(status_en), .state(state));

    sbc_host_model #(.N_CHAIN(2)) sbc_host_model_inst (.sck(sck), .convert_start(convert_start),
        .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Every bit the host saw must be driven and equal to the model's bit.
    task automatic check_stream();
        check(sbc_host_model_inst.got.size(), exp_q.size());
        while (exp_q.size() > 0 && sbc_host_model_inst.got.size() > 0) begin
            check(sbc_host_model_inst.got.pop_front(), {1'h1, exp_q.pop_front()});
        end
        exp_q.delete();
        sbc_host_model_inst.got.delete();
    endtask

    task automatic new_result(input logic with_status);
        @(posedge clk);
        #1 result_data = 20'($random(seed));
        status_data = 6'($random(seed));
        for (int i = 19; i >= 0; i--) exp_q.push_back(result_data[i]);
        if (with_status) begin
            for (int i = 5; i >= 0; i--) exp_q.push_back(status_data[i]);
        end
    endtask

    task automatic busy_frame(input logic with_status);
        exp_q.push_back(1'h0);
        new_result(with_status);
        sbc_host_model_inst.start_conv(1'h1);
        repeat (6) @(posedge clk);
        #1 check({sdo_oe, acquire, state}, {2'h0, SBC_CONVERT});
        repeat (20) @(posedge clk);
        #1 check({sdo_oe, sdo_o, acquire, state}, {3'h5, SBC_READ});
        sbc_host_model_inst.got.delete();
        sbc_host_model_inst.pulses(exp_q.size());
        #1 check(sdo_oe, 1'h0);
        check_stream();
        sbc_host_model_inst.end_conv();
        repeat (8) @(posedge clk);
    endtask

    initial begin
        #40000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        result_data = 20'($random(seed));
        status_data = 6'($random(seed));
        fork
            sbc_host_model_inst.pulses(5);
            repeat (20) @(posedge clk);
        join
        #1 reset = 1'h0;
        @(posedge clk);
        #1 check({turbo_en, status_en, acquire, state}, {3'h1, SBC_IDLE});
        // The link-side reset only lets go after two serial clock edges without reset.
        sbc_host_model_inst.pulses(2);
        busy_frame(1'h0);
        @(posedge clk);
        #1 chain_mode = 1'h1;
        repeat (4) @(posedge clk);
        #1 check({sdo_oe, sdo_o}, 2'h2);
        cfg_word = {`SBC_WRITE_CMD, 8'h01};
        for (int i = 0; i < 16; i++) exp_q.push_back((i < 8) ? 1'h0 : cfg_word[23 - i]);
        sbc_host_model_inst.got.delete();
        sbc_host_model_inst.write_cfg(8'h01, 1);
        check_stream();
        new_result(1'h1);
        sbc_host_model_inst.start_conv(1'h0);
        repeat (6) @(posedge clk);
        #1 check({sdo_oe, sdo_o, turbo_en, status_en}, 4'h9);
        repeat (20) @(posedge clk);
        up_word = 26'($random(seed));
        for (int i = 25; i >= 0; i--) begin
            exp_q.push_back(up_word[i]);
            sbc_host_model_inst.feed.push_back(up_word[i]);
        end
        sbc_host_model_inst.got.delete();
        sbc_host_model_inst.pulses(sbc_host_model_inst.read_clocks(1'h1));
        check_stream();
        sbc_host_model_inst.end_conv();
        @(posedge clk);
        #1 chain_mode = 1'h0;
        repeat (8) @(posedge clk);
        busy_frame(1'h1);
        check(n_starts, 3);
        stop_test();
    end
endmodule
